//--- core/dbg_pkg.sv
// Constants, command codes and state types of the debug command engine
package dbg_pkg;

  // ----------------------------------------------------------------
  // Command opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_BACKGROUND = 8'h90;
  localparam logic [7:0] OP_ACK_ON = 8'hd5;
  localparam logic [7:0] OP_ACK_OFF = 8'hd6;
  // Memory and debug register access codes; values are arbitrary
  localparam logic [7:0] OP_READ_BYTE = 8'he0;
  localparam logic [7:0] OP_READ_WORD = 8'he8;
  localparam logic [7:0] OP_WRITE_BYTE = 8'hc0;
  localparam logic [7:0] OP_WRITE_WORD = 8'hc8;
  localparam logic [7:0] OP_REG_READ = 8'he4;
  localparam logic [7:0] OP_REG_WRITE = 8'hc4;

  // ----------------------------------------------------------------
  // Widths, counts, address window, reset values
  // ----------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam int BYTE_W = 8;
  localparam int ADDR_BYTES = 3;
  localparam int BITS_PER_BYTE = 8;
  localparam int FREE_WAIT_CYCLES = 128;
  localparam logic [17:0] DBG_REG_FIRST = 18'h3ff00;
  localparam logic [17:0] DBG_REG_LAST = 18'h3ff0b;
  localparam logic ACK_EN_RESET = 1'b0;
  localparam logic ACTIVE_BG_RESET = 1'b0;

  // ----------------------------------------------------------------
  // Engine states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_ACCESS} eng_state_t;

endpackage

//--- core/byte_link_if.sv
// Received command byte stream between receiver and engine
`timescale 1ns/1ps
interface byte_link_if;
  logic [7:0] data;
  logic valid;
  modport src (output data, output valid);
  modport dst (input data, input valid);
endinterface

//--- core/serial_cmd_rx.sv
// Serial receiver that assembles link bits into command bytes
`timescale 1ns/1ps
module serial_cmd_rx
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Raw link pins
  input wire logic link_data,
  input wire logic link_strobe,
  // Assembled bytes
  byte_link_if.src bytes
);

  typedef struct packed
  {
    logic d_meta;
    logic d_sync;
    logic s_meta;
    logic s_sync;
    logic s_prev;
    logic [7:0] shift;
    logic [2:0] cnt;
    logic [7:0] byte_out;
    logic valid;
  } rx_state_t;

  rx_state_t st_reg;
  rx_state_t st_next;

  // ----------------------------------------------------------------
  // Bit assembly
  // ----------------------------------------------------------------
  // Only the second sync stages feed the edge detect and shifter
  always_comb
  begin
    st_next = st_reg;
    st_next.d_meta = link_data;
    st_next.d_sync = st_reg.d_meta;
    st_next.s_meta = link_strobe;
    st_next.s_sync = st_reg.s_meta;
    st_next.s_prev = st_reg.s_sync;
    st_next.valid = 1'b0;
    if (st_reg.s_sync && !st_reg.s_prev)
    begin
      st_next.shift = {st_reg.shift[6:0], st_reg.d_sync};
      st_next.cnt = st_reg.cnt + 3'd1;
      if (st_reg.cnt == 3'(dbg_pkg::BITS_PER_BYTE - 1))
      begin
        st_next.byte_out = {st_reg.shift[6:0], st_reg.d_sync};
        st_next.valid = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign bytes.data = st_reg.byte_out;
  assign bytes.valid = st_reg.valid;

endmodule // serial_cmd_rx

//--- core/debug_hw_command_engine.sv
// Hardware command engine of the background debug unit
// Notes on behaviour
// - Commands read and write any CPU-visible location and enter active debug mode.
// - Commands run in or out of active debug mode, barely touching the CPU.
// - A memory access waits for a bus cycle the CPU leaves unused.
// - After 128 clocks without a free cycle, freeze the CPU and steal one.
// - A single-cycle access in a free cycle never stalls the CPU.
// - Multi-cycle access keeps the CPU frozen from its start until done.
// - Debug register select is asserted only during its own access cycle.
// - Opcode 90 enters active debug mode only when enabled, acknowledging entry only while the handshake is on.
// - Opcode D5 turns the handshake on and emits an acknowledge pulse.
// - Opcode D6 turns the handshake off without any acknowledge pulse.
// - With debugging disabled, enter-debug commands are ignored and cost no delay.
// - Debug registers sit at 0x3_FF00 to 0x3_FF0B, reachable only by debug logic.
`timescale 1ns/1ps
module debug_hw_command_engine
#(
  parameter int WAIT_CYCLES = dbg_pkg::FREE_WAIT_CYCLES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial debug link pins
  input wire logic link_data,
  input wire logic link_strobe,
  output logic ack_pulse,
  // Debug mode control
  input wire logic debug_enable,
  input wire logic bg_exit,
  output logic active_bg,
  output logic bg_entry,
  // System bus
  input wire logic bus_free,
  input wire logic [7:0] bus_rdata,
  output logic bus_req,
  output logic bus_we,
  output logic [17:0] bus_addr,
  output logic [7:0] bus_wdata,
  output logic dbg_reg_sel,
  output logic cpu_freeze,
  // Read data back to the link
  output logic [7:0] rdata,
  output logic rdata_valid,
  output logic busy
);

  // Wait counter is eight bits wide, so larger waits cannot be served
  if (WAIT_CYCLES < 1 || WAIT_CYCLES > 255)
  begin : g_bad_wait
    $error("WAIT_CYCLES must lie between 1 and 255");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed
  {
    dbg_pkg::eng_state_t state;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic [1:0] cnt;
    logic word;
    logic write;
    logic regs;
    logic phase;
    logic [7:0] wait_cnt;
    logic freeze;
    logic ack_en;
    logic active;
    logic entry;
    logic ack;
    logic [7:0] rdata;
    logic rvalid;
  } eng_t;

  eng_t st_reg;
  eng_t st_next;
  logic grant;

  byte_link_if rx_bytes ();

  serial_cmd_rx u_rx
  (
    .clk(clk),
    .rst(rst),
    .link_data(link_data),
    .link_strobe(link_strobe),
    .bytes(rx_bytes.src)
  );

  // True when an address falls in the debug register window
  function automatic logic in_dbg_window(input logic [17:0] a);
    in_dbg_window = (a >= dbg_pkg::DBG_REG_FIRST) && (a <= dbg_pkg::DBG_REG_LAST);
  endfunction

  // ----------------------------------------------------------------
  // Bus grant
  // ----------------------------------------------------------------
  // take an unused cycle
  assign grant = (st_reg.state == dbg_pkg::ST_ACCESS) && (bus_free || st_reg.freeze);

  // ----------------------------------------------------------------
  // Command sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    st_next.entry = 1'b0;
    st_next.ack = 1'b0;
    st_next.rvalid = 1'b0;
    if (bg_exit)
      st_next.active = 1'b0;
    case (st_reg.state)
      dbg_pkg::ST_IDLE:
      begin
        if (rx_bytes.valid)
        begin
          st_next.cnt = 2'd0;
          st_next.phase = 1'b0;
          st_next.wait_cnt = 8'h00;
          st_next.addr = 24'h000000;
          st_next.word = (rx_bytes.data == dbg_pkg::OP_READ_WORD) ||
                         (rx_bytes.data == dbg_pkg::OP_WRITE_WORD);
          st_next.write = (rx_bytes.data == dbg_pkg::OP_WRITE_BYTE) ||
                          (rx_bytes.data == dbg_pkg::OP_WRITE_WORD) ||
                          (rx_bytes.data == dbg_pkg::OP_REG_WRITE);
          st_next.regs = (rx_bytes.data == dbg_pkg::OP_REG_READ) ||
                         (rx_bytes.data == dbg_pkg::OP_REG_WRITE);
          if (rx_bytes.data == dbg_pkg::OP_BACKGROUND)
          begin
            if (debug_enable && !st_reg.active)
            begin
              st_next.active = 1'b1;
              st_next.entry = 1'b1;
              st_next.ack = st_reg.ack_en;
            end
          end
          else if (rx_bytes.data == dbg_pkg::OP_ACK_ON)
          begin
            st_next.ack_en = 1'b1;
            st_next.ack = 1'b1;
          end
          else if (rx_bytes.data == dbg_pkg::OP_ACK_OFF)
          begin
            st_next.ack_en = 1'b0;
          end
          else if (rx_bytes.data == dbg_pkg::OP_READ_BYTE ||
                   rx_bytes.data == dbg_pkg::OP_READ_WORD ||
                   rx_bytes.data == dbg_pkg::OP_WRITE_BYTE ||
                   rx_bytes.data == dbg_pkg::OP_WRITE_WORD ||
                   rx_bytes.data == dbg_pkg::OP_REG_READ ||
                   rx_bytes.data == dbg_pkg::OP_REG_WRITE)
          begin
            st_next.state = dbg_pkg::ST_ADDR;
          end
        end
      end
      dbg_pkg::ST_ADDR:
      begin
        // Address arrives high byte first
        if (rx_bytes.valid)
        begin
          st_next.addr = {st_reg.addr[15:0], rx_bytes.data};
          st_next.cnt = st_reg.cnt + 2'd1;
          if (st_reg.cnt == 2'(dbg_pkg::ADDR_BYTES - 1))
          begin
            st_next.cnt = 2'd0;
            // register commands outside the window are dropped
            if (st_reg.regs && !in_dbg_window({st_reg.addr[9:0], rx_bytes.data}))
              st_next.state = dbg_pkg::ST_IDLE;
            else if (st_reg.write)
              st_next.state = dbg_pkg::ST_DATA;
            else
              st_next.state = dbg_pkg::ST_ACCESS;
          end
        end
      end
      dbg_pkg::ST_DATA:
      begin
        // Word data high byte first
        if (rx_bytes.valid)
        begin
          st_next.wdata = {st_reg.wdata[7:0], rx_bytes.data};
          st_next.cnt = st_reg.cnt + 2'd1;
          if (!st_reg.word || st_reg.cnt == 2'd1)
            st_next.state = dbg_pkg::ST_ACCESS;
        end
      end
      dbg_pkg::ST_ACCESS:
      begin
        if (grant)
        begin
          if (!st_reg.write)
          begin
            st_next.rdata = bus_rdata;
            st_next.rvalid = 1'b1;
          end
          if (st_reg.word && !st_reg.phase)
          begin
            // hold CPU for the second beat
            st_next.phase = 1'b1;
            st_next.freeze = 1'b1;
            st_next.addr = st_reg.addr + 24'h000001;
          end
          else
          begin
            // release at once after the last beat
            st_next.freeze = 1'b0;
            st_next.ack = st_reg.ack_en;
            st_next.state = dbg_pkg::ST_IDLE;
          end
        end
        else
        begin
          st_next.wait_cnt = st_reg.wait_cnt + 8'h01;
          // steal a cycle after the wait
          if (st_reg.wait_cnt == 8'(WAIT_CYCLES - 1))
            st_next.freeze = 1'b1;
        end
      end
      default:
        st_next.state = dbg_pkg::ST_IDLE;
    endcase
  end

  // State register; bytes arriving during an access are dropped
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_reg <= '0;
      st_reg.state <= dbg_pkg::ST_IDLE;
      st_reg.ack_en <= dbg_pkg::ACK_EN_RESET;
      st_reg.active <= dbg_pkg::ACTIVE_BG_RESET;
    end
    else
      st_reg <= st_next;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // bus access regardless of mode
  assign bus_req = grant;
  assign bus_we = grant && st_reg.write;
  assign bus_addr = st_reg.addr[17:0];
  assign bus_wdata = (st_reg.word && !st_reg.phase) ? st_reg.wdata[15:8] : st_reg.wdata[7:0];
  // private registers only in their cycle
  assign dbg_reg_sel = grant && st_reg.regs;
  // freeze from the first beat of a word
  assign cpu_freeze = st_reg.freeze || (grant && st_reg.word && !st_reg.phase);
  assign ack_pulse = st_reg.ack;
  assign active_bg = st_reg.active;
  assign bg_entry = st_reg.entry;
  assign rdata = st_reg.rdata;
  assign rdata_valid = st_reg.rvalid;
  assign busy = (st_reg.state != dbg_pkg::ST_IDLE);

endmodule // debug_hw_command_engine

//--- tb/dbg_chk.sv
// Port-level assertions for the debug command engine
`timescale 1ns/1ps
module dbg_chk
#(
  parameter int WAIT_CYCLES = 128
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link and mode
  input wire logic link_data,
  input wire logic link_strobe,
  input wire logic ack_pulse,
  input wire logic debug_enable,
  input wire logic bg_exit,
  input wire logic active_bg,
  input wire logic bg_entry,
  // Bus and read back
  input wire logic bus_free,
  input wire logic [7:0] bus_rdata,
  input wire logic bus_req,
  input wire logic bus_we,
  input wire logic [17:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic dbg_reg_sel,
  input wire logic cpu_freeze,
  input wire logic [7:0] rdata,
  input wire logic rdata_valid,
  input wire logic busy
);
  // --------
  // Checks
  // --------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_grant_cause: assert property (bus_req |-> bus_free || cpu_freeze)
    else $error("grant without free cycle or freeze");
  a_sel_grant: assert property (dbg_reg_sel |-> bus_req && bus_addr >= dbg_pkg::DBG_REG_FIRST
    && bus_addr <= dbg_pkg::DBG_REG_LAST)
    else $error("register select outside grant or window");
  a_steal_now: assert property ($rose(cpu_freeze) |-> bus_req)
    else $error("freeze without a stolen cycle");
  a_freeze_brief: assert property (cpu_freeze ##1 cpu_freeze |=> !cpu_freeze)
    else $error("freeze held beyond two beats");
  a_word_frozen: assert property (bus_req && $past(bus_req) |->
    cpu_freeze && bus_addr == $past(bus_addr) + 18'h1)
    else $error("second beat not frozen or not next address");
  a_rv_read: assert property (rdata_valid |-> $past(bus_req) && !$past(bus_we))
    else $error("read valid without read grant");
  a_rv_data: assert property (rdata_valid |-> rdata == $past(bus_rdata))
    else $error("read data not from grant cycle");
  a_freeze_busy: assert property (cpu_freeze |-> busy || $past(busy))
    else $error("freeze while idle");
  a_entry_en: assert property ($rose(active_bg) |-> $past(debug_enable))
    else $error("active mode entered while disabled");
  // Main scenarios
  c_steal: cover property (bus_req && !bus_free);
  c_reg: cover property (dbg_reg_sel);
  c_entry: cover property (bg_entry);
endmodule // dbg_chk

bind debug_hw_command_engine dbg_chk #(.WAIT_CYCLES(WAIT_CYCLES)) chk_u (.*);

//--- tb/dbg_host.sv
// Debug host model sending command bytes on the link pins
`timescale 1ns/1ps
module dbg_host
(
  // Clock
  input wire logic clk,
  // Link pins
  output logic link_data,
  output logic link_strobe
);
  // Strobe stands low between frames
  initial
  begin
    link_data = 1'b0;
    link_strobe = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // eight bits MSB first
  // Phases of 2..4 clocks clear the 2FF sync with margin
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      link_data = b[i];
      tick(3);
      link_strobe = 1'b1;
      tick(4);
      link_strobe = 1'b0;
      // Past hold the line shows the inverse, not a stale bit
      link_data = ~b[i];
      tick(2);
    end
  endtask
endmodule // dbg_host

//--- tb/tb_top.sv
// Self-checking bench for the debug command engine
`timescale 1ns/1ps
module tb_top;
  // --------
  // Bench
  // --------
  // Short steal wait keeps the run brief
  localparam int WAITS = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic debug_enable = 1'b0;
  logic bg_exit = 1'b0;
  logic bus_free = 1'b1;
  logic link_data, link_strobe, ack_pulse, active_bg, bg_entry, bus_req, bus_we;
  logic dbg_reg_sel, cpu_freeze, rdata_valid, busy;
  logic [17:0] bus_addr, wr_addr;
  logic [7:0] bus_wdata, rdata, wr_data;
  int err_count = 0;
  int total_checks = 0;
  int n_ack, n_ent, n_req, n_sel, n_rv, n_frz;
  int n_wait = 0;
  // Memory answers with a pattern of its address
  wire logic [7:0] bus_rdata = bus_addr[7:0] ^ 8'h5a;
  always #2.5 clk = ~clk;
  dbg_host host_u (.clk(clk), .link_data(link_data), .link_strobe(link_strobe));
  debug_hw_command_engine #(.WAIT_CYCLES(WAITS)) dut_u
  (
    .clk(clk),
    .rst(rst),
    .link_data(link_data),
    .link_strobe(link_strobe),
    .ack_pulse(ack_pulse),
    .debug_enable(debug_enable),
    .bg_exit(bg_exit),
    .active_bg(active_bg),
    .bg_entry(bg_entry),
    .bus_free(bus_free),
    .bus_rdata(bus_rdata),
    .bus_req(bus_req),
    .bus_we(bus_we),
    .bus_addr(bus_addr),
    .bus_wdata(bus_wdata),
    .dbg_reg_sel(dbg_reg_sel),
    .cpu_freeze(cpu_freeze),
    .rdata(rdata),
    .rdata_valid(rdata_valid),
    .busy(busy)
  );
  // Event counters and last write seen
  always @(posedge clk)
  begin
    n_ack += (ack_pulse === 1'b1);
    n_ent += (bg_entry === 1'b1);
    n_req += (bus_req === 1'b1);
    n_sel += (dbg_reg_sel === 1'b1);
    n_rv += (rdata_valid === 1'b1);
    n_frz += (cpu_freeze === 1'b1);
    if (bus_req === 1'b1 && bus_we === 1'b1)
    begin
      wr_addr <= bus_addr;
      wr_data <= bus_wdata;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [31:0] got, exp, input string m);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: %s got %0h", $time, m, got);
    end
  endtask
  task automatic clr;
    {n_ack, n_ent, n_req, n_sel, n_rv, n_frz} = '0;
  endtask
  // Bounded wait for the engine to go idle; n_wait keeps the clocks spent
  task automatic op1(input logic [7:0] op);
    host_u.send_byte(op);
    n_wait = 0;
    while (busy !== 1'b0 && n_wait < 300)
    begin
      tick(1);
      n_wait++;
    end
    if (busy !== 1'b0)
    begin
      err_count++;
      $display("unexpected at %0t: engine stuck busy", $time);
    end
    tick(3);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [17:0] a, input int nd, input logic [15:0] d);
    host_u.send_byte(op);
    host_u.send_byte({6'h00, a[17:16]});
    host_u.send_byte(a[15:8]);
    if (nd == 0) op1(a[7:0]);
    else host_u.send_byte(a[7:0]);
    if (nd == 2) host_u.send_byte(d[15:8]);
    if (nd > 0) op1(d[7:0]);
  endtask
  task automatic t_ack;
    clr();
    op1(dbg_pkg::OP_ACK_ON);
    op1(8'hab);
    check(n_ack, 1, "ack on");
    clr();
    op1(dbg_pkg::OP_ACK_OFF);
    check(n_ack, 0, "ack off");
    $display("test ack done");
  endtask
  task automatic t_bg;
    op1(dbg_pkg::OP_ACK_ON);
    clr();
    op1(dbg_pkg::OP_BACKGROUND);
    check({active_bg, n_ent[3:0], n_frz[3:0]}, 0, "disabled entry");
    debug_enable = 1'b1;
    clr();
    op1(dbg_pkg::OP_BACKGROUND);
    check({active_bg, n_ent[3:0], n_ack[3:0]}, 9'h111, "entry");
    bg_exit = 1'b1;
    tick(1);
    bg_exit = 1'b0;
    tick(2);
    check(active_bg, 0, "exit");
    $display("test background done");
  endtask
  task automatic t_read;
    clr();
    cmd(dbg_pkg::OP_READ_BYTE, 18'h01234, 0, 16'h0000);
    check({rdata, n_req[3:0], n_rv[3:0], n_frz[3:0]}, 20'h6e110, "free read");
    check(n_wait, 0, "free read wait");
    bus_free = 1'b0;
    clr();
    cmd(dbg_pkg::OP_READ_WORD, 18'h2a0f0, 0, 16'h0000);
    bus_free = 1'b1;
    check({rdata, n_req[3:0], n_rv[3:0]}, 16'hab22, "stolen word");
    check(n_frz != 0, 1, "steal freeze");
    check(n_wait, WAITS, "steal wait");
    $display("test read done");
  endtask
  task automatic t_write;
    clr();
    cmd(dbg_pkg::OP_WRITE_WORD, 18'h00100, 2, 16'hbeef);
    check({wr_addr, wr_data, n_sel[3:0]}, 30'h0101ef0, "word write");
    check(n_frz != 0, 1, "word freeze");
    clr();
    cmd(dbg_pkg::OP_REG_READ, 18'h3ff00, 0, 16'h0000);
    check({rdata, n_sel[3:0]}, 12'h5a1, "reg read");
    clr();
    cmd(dbg_pkg::OP_REG_WRITE, 18'h3ff0b, 1, 16'h0042);
    check({wr_data, n_sel[3:0]}, 12'h421, "reg write");
    clr();
    cmd(dbg_pkg::OP_REG_WRITE, 18'h3ff0c, 1, 16'h0042);
    cmd(dbg_pkg::OP_WRITE_BYTE, 18'h00200, 1, 16'h0033);
    check({wr_addr, wr_data, n_sel[3:0]}, 30'h0200330, "out of window");
    $display("test write done");
  endtask
  // Mid-run reset must drop the handshake back to off
  task automatic t_reset;
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(1);
    check({active_bg, busy, ack_pulse}, 0, "after reset");
    clr();
    op1(dbg_pkg::OP_BACKGROUND);
    check({active_bg, n_ent[3:0], n_ack[3:0]}, 9'h110, "entry after reset");
    $display("test reset done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Whole run is some 3000 clocks; allow over six times that
  initial
  begin
    #100000;
    err_count++;
    $display("unexpected at %0t: watchdog", $time);
    conclude();
  end
  initial
  begin
    tick(2);
    rst = 1'b0;
    tick(1);
    t_ack();
    t_bg();
    t_read();
    t_write();
    t_reset();
    conclude();
  end
endmodule // tb_top
